// ---- rtl/rcco_top.sv ----
`timescale 1ns/1ps
// What this block does
// RULE1: Override bit 31 makes this register's fields win; resets to zero.
// RULE2: Divisor field bits 28:23, read/write, resets to 0x0F.
// RULE3: Six-bit divisor reaches beyond sixteen; all ones divides by 64.
// RULE4: Divisor applies to the fixed 400 MHz VCO when PLL is used.
// RULE5: Bit 13 powers down the PLL; resets to one.
// RULE6: Bit 11 bypasses the PLL; resets to one.
// RULE7: Oscillator select bits 6:4, resets to internal oscillator.
// RULE8: Source codes: 0 main, 1 internal, 2 internal/4, 3 30 kHz, 7 32 kHz.
// RULE9: Reserved bits read zero and ignore writes; software preserves them.
// RULE10: Register at offset 0x070, resets to 0x07802810.
// RULE11: Divide ratio is divisor field plus one.
module rcco_top
  import rcco_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             pll_power_down,
  output logic             pll_bypass_sel,
  output logic [2:0]       osc_source_sel,
  output logic [6:0]       sys_div_ratio,
  output logic [9:0]       sys_clk_mhz_x16,
  output logic             sys_clk_tick
);
  logic [31:0] ext_q;
  logic [31:0] pri_q;
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  rcco_cfg_t   cfg_q;
  rcco_cfg_if  cif ();

  // Address phase decode
  wire        addr_take = hsel && hready && htrans[1];
  wire [11:0] a_off     = haddr[RCCO_AW-1:0];
  wire        hit_ext   = a_off == RCCO_OFF_EXT;
  wire        hit_pri   = a_off == RCCO_OFF_PRIMARY;
  wire        hit_sts   = a_off == RCCO_OFF_STATUS;
  wire        wr_ext    = wr_pend_q && (wr_addr_q == RCCO_OFF_EXT); // RULE10
  wire        wr_pri    = wr_pend_q && (wr_addr_q == RCCO_OFF_PRIMARY);
  wire [31:0] sts_word  = {14'h0000, sys_clk_mhz_x16, cfg_q.pll_power_down,
                           cfg_q.pll_bypass_sel, cfg_q.osc_source_sel, 3'h0};
  wire [31:0] rd_word   = hit_ext ? ext_q : hit_pri ? pri_q : hit_sts ? sts_word : 32'h00000000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata    <= 32'h00000000;
    end else begin
      wr_pend_q <= addr_take && hwrite;
      if (addr_take) begin
        wr_addr_q <= a_off;
        if (!hwrite) begin
          hrdata <= rd_word;
        end
      end
    end
  end

  // Reserved bits never take write data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_q <= RCCO_EXT_RESET; // RULE1 RULE2 RULE5 RULE6 RULE7 RULE10
      pri_q <= RCCO_PRIMARY_RESET;
    end else begin
      if (wr_ext) begin
        ext_q <= hwdata & RCCO_EXT_WMASK; // RULE9
      end
      if (wr_pri) begin
        pri_q <= hwdata & RCCO_PRIMARY_WMASK;
      end
    end
  end

  assign cif.ext_q = ext_q;
  assign cif.pri_q = pri_q;
  rcco_cfg_select u_sel (.cif(cif.sel));

  // Registered so the clock tree sees glitch-free controls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= '{pll_power_down: 1'b1, pll_bypass_sel: 1'b1,
                 osc_source_sel: RCCO_OSC_INT, sys_div_ratio: 7'h10};
    end else begin
      cfg_q <= cif.cfg;
    end
  end

  assign pll_power_down = cfg_q.pll_power_down;
  assign pll_bypass_sel = cfg_q.pll_bypass_sel;
  assign osc_source_sel = cfg_q.osc_source_sel; // RULE8
  assign sys_div_ratio  = cfg_q.sys_div_ratio;

  // Nominal 400 MHz VCO divided; scaled by 16 to keep fractions
  localparam logic [12:0] VCO_X16 = 13'(RCCO_VCO_MHZ * 16);
  wire         pll_used = !cfg_q.pll_bypass_sel && !cfg_q.pll_power_down;
  wire  [12:0] quot     = VCO_X16 / {6'h00, cfg_q.sys_div_ratio};
  // Ratios below seven overflow ten bits; saturate rather than wrap
  wire         quot_big = |quot[12:10];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_clk_mhz_x16 <= 10'h000;
    end else begin
      sys_clk_mhz_x16 <= pll_used ? (quot_big ? 10'h3FF : quot[9:0]) : 10'h000; // RULE4
    end
  end

  rcco_divider #(.RW(7)) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ratio   (cfg_q.sys_div_ratio),
    .run     (pll_used),
    .tick    (sys_clk_tick)
  );

  ovr_reset_a: assert property (@(posedge hclk) $rose(hresetn) |-> ext_q == RCCO_EXT_RESET)
    else $error("ext reg not at reset value"); // RULE10
  rsv_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ext_q & ~RCCO_EXT_WMASK) == 32'h00000000) else $error("reserved bit set"); // RULE9
  ovr_div_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_q[RCCO_USE_BIT] |=> sys_div_ratio == {1'b0, $past(ext_q[28:23])} + 7'h01)
    else $error("override ratio wrong"); // RULE1
  div_max_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ext_q[31] && ext_q[28:23] == 6'h3F) |=> sys_div_ratio == 7'h40)
    else $error("all ones not 64"); // RULE3
  ratio_plus_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_q[31] |=> sys_div_ratio != {1'b0, $past(ext_q[28:23])})
    else $error("ratio not plus one"); // RULE11
  pwd_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_q[31] |=> pll_power_down == $past(ext_q[13])) else $error("pwd wrong"); // RULE5
  byp_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_q[31] |=> pll_bypass_sel == $past(ext_q[11])) else $error("bypass wrong"); // RULE6
  osc_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_q[31] |=> osc_source_sel == $past(ext_q[6:4])) else $error("osc wrong"); // RULE7
  div_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ext |=> ext_q[28:23] == $past(hwdata[28:23])) else $error("divisor lost"); // RULE2
  freq_calc_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (pll_used && sys_div_ratio == 7'h40) [*2] |-> sys_clk_mhz_x16 == 10'd100)
    else $error("vco not 400"); // RULE4

  ovr_on_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(ext_q[31]));
  pll_run_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(pll_used));
  div64_c: cover property (@(posedge hclk) disable iff (!hresetn) sys_div_ratio == 7'h40);
endmodule

// ---- rtl/rcco_pkg.sv ----
package rcco_pkg;
  localparam int          RCCO_AW            = 12;
  localparam logic [11:0] RCCO_OFF_EXT       = 12'h070;
  localparam logic [11:0] RCCO_OFF_PRIMARY   = 12'h060;
  localparam logic [11:0] RCCO_OFF_STATUS    = 12'h074;
  localparam logic [31:0] RCCO_EXT_RESET     = 32'h07802810;
  localparam logic [31:0] RCCO_EXT_WMASK     = 32'h9F802870;
  localparam int          RCCO_USE_BIT       = 31;
  localparam int          RCCO_DIV_MSB       = 28;
  localparam int          RCCO_DIV_LSB       = 23;
  localparam int          RCCO_PWD_BIT       = 13;
  localparam int          RCCO_BYP_BIT       = 11;
  localparam int          RCCO_OSC_MSB       = 6;
  localparam int          RCCO_OSC_LSB       = 4;
  localparam int          RCCO_BASEDIV_MSB   = 26;
  localparam int          RCCO_BASEDIV_LSB   = 23;
  localparam logic [31:0] RCCO_PRIMARY_RESET = 32'h078E3AD1;
  localparam logic [31:0] RCCO_PRIMARY_WMASK = 32'h07C03BF3;
  localparam int          RCCO_PRI_OSC_MSB   = 5;
  localparam int          RCCO_PRI_OSC_LSB   = 4;
  localparam int          RCCO_VCO_MHZ       = 400;
  localparam int          RCCO_CLK_MHZ       = 25;
  localparam logic [2:0]  RCCO_OSC_MAIN      = 3'h0;
  localparam logic [2:0]  RCCO_OSC_INT       = 3'h1;
  localparam logic [2:0]  RCCO_OSC_INT_DIV4  = 3'h2;
  localparam logic [2:0]  RCCO_OSC_30K       = 3'h3;
  localparam logic [2:0]  RCCO_OSC_32K_EXT   = 3'h7;
  typedef struct packed {
    logic       pll_power_down;
    logic       pll_bypass_sel;
    logic [2:0] osc_source_sel;
    logic [6:0] sys_div_ratio;
  } rcco_cfg_t;
endpackage

// ---- rtl/rcco_cfg_if.sv ----
`timescale 1ns/1ps
interface rcco_cfg_if;
  import rcco_pkg::*;
  logic [31:0] ext_q;
  logic [31:0] pri_q;
  rcco_cfg_t   cfg;
  modport src (output ext_q, output pri_q, input cfg);
  modport sel (input ext_q, input pri_q, output cfg);
endinterface

// ---- rtl/rcco_cfg_select.sv ----
`timescale 1ns/1ps
module rcco_cfg_select
  import rcco_pkg::*;
(
  rcco_cfg_if.sel cif
);
  wire        use_alt_clock_config = cif.ext_q[RCCO_USE_BIT];
  wire [5:0]  sysclk_divisor_ext   = cif.ext_q[RCCO_DIV_MSB:RCCO_DIV_LSB];
  wire [3:0]  sysclk_divisor_base  = cif.pri_q[RCCO_BASEDIV_MSB:RCCO_BASEDIV_LSB];
  wire [2:0]  base_osc             = {1'b0, cif.pri_q[RCCO_PRI_OSC_MSB:RCCO_PRI_OSC_LSB]};
  wire [6:0]  ext_ratio            = {1'b0, sysclk_divisor_ext} + 7'h01;
  wire [6:0]  base_ratio           = {3'h0, sysclk_divisor_base} + 7'h01;
  // Override chooses every field as a group
  assign cif.cfg.pll_power_down = use_alt_clock_config ? cif.ext_q[RCCO_PWD_BIT]
                                                       : cif.pri_q[RCCO_PWD_BIT]; // RULE1 RULE5
  assign cif.cfg.pll_bypass_sel = use_alt_clock_config ? cif.ext_q[RCCO_BYP_BIT]
                                                       : cif.pri_q[RCCO_BYP_BIT]; // RULE1 RULE6
  assign cif.cfg.osc_source_sel = use_alt_clock_config ? cif.ext_q[RCCO_OSC_MSB:RCCO_OSC_LSB]
                                                       : base_osc; // RULE1 RULE7
  assign cif.cfg.sys_div_ratio  = use_alt_clock_config ? ext_ratio : base_ratio; // RULE3 RULE11
endmodule

// ---- rtl/rcco_divider.sv ----
`timescale 1ns/1ps
module rcco_divider #(
  parameter int RW = 7
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic [RW-1:0] ratio,
  input  wire logic          run,
  output logic               tick
);
  logic [RW-1:0] cnt_q;
  initial begin
    if (RW < 7) $error("ratio width too small for divide by 64");
  end
  wire last = (cnt_q + {{(RW-1){1'b0}}, 1'b1}) >= ratio;
  // Model of the system clock enable: one pulse per ratio cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= run && last;
      cnt_q <= (!run || last) ? '0 : cnt_q + {{(RW-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ---- test/rcco_top_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module rcco_top_tb_top
  import rcco_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        pll_power_down;
  logic        pll_bypass_sel;
  logic [2:0]  osc_source_sel;
  logic [6:0]  sys_div_ratio;
  logic [9:0]  sys_clk_mhz_x16;
  logic        sys_clk_tick;
  logic [31:0] rd;
  int          n_mismatch;
  int          checks_done;
  int          n;
  logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};

  rcco_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pll_power_down(pll_power_down),
    .pll_bypass_sel(pll_bypass_sel), .osc_source_sel(osc_source_sel),
    .sys_div_ratio(sys_div_ratio), .sys_clk_mhz_x16(sys_clk_mhz_x16),
    .sys_clk_tick(sys_clk_tick));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Waits on hready so a stalling slave is still served
  task automatic wait_ready();
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  // Counts edges up to the next tick; a missing tick ends the run
  task automatic wait_tick();
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (sys_clk_tick !== 1'b1 && n < 200);
    if (n >= 200) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  // Outputs settle one edge after the data phase; sample past that edge
  task automatic chk_cfg(input logic p, input logic b, input logic [2:0] o,
                         input logic [6:0] r);
    @(posedge hclk);
    #1;
    `CHK({pll_power_down, pll_bypass_sel, osc_source_sel, sys_div_ratio}, {p, b, o, r})
  endtask

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 32'h00000070, 32'h0);
    `CHK(rd, 32'h07802810)
    chk_cfg(1'b1, 1'b1, 3'h1, 7'h10);
    $display("test reset_values done");
    bus(1'b1, 32'h00000070, 32'hFFFFFFFF);
    bus(1'b0, 32'h00000070, 32'h0);
    `CHK(rd, 32'h9F802870)
    chk_cfg(1'b1, 1'b1, 3'h7, 7'h40);
    $display("test all_ones done");
    bus(1'b1, 32'h00000070, 32'h84800010);
    chk_cfg(1'b0, 1'b0, 3'h1, 7'h0A);
    wait_tick();
    wait_tick();
    `CHK(n, 10)
    `CHK(sys_clk_mhz_x16, 10'd640)
    bus(1'b0, 32'h00000074, 32'h0);
    `CHK(rd, 32'h00028008)
    $display("test pll_divide done");
    bus(1'b1, 32'h00000070, 32'h9F800070);
    chk_cfg(1'b0, 1'b0, 3'h7, 7'h40);
    wait_tick();
    wait_tick();
    `CHK(n, 64)
    `CHK(sys_clk_mhz_x16, 10'd100)
    $display("test pll_div64 done");
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 32'h00000070, {25'h1000000, codes[i], 4'h0} | 32'h00002800);
      chk_cfg(1'b1, 1'b1, codes[i], 7'h01);
    end
    $display("test osc_codes done");
    bus(1'b1, 32'h00000070, 32'h7F802070);
    chk_cfg(1'b1, 1'b1, 3'h1, 7'h10);
    bus(1'b0, 32'h00000070, 32'h0);
    `CHK(rd, 32'h1F802070)
    $display("test override_off done");
    bus(1'b1, 32'h00000100, 32'hFFFFFFFF);
    bus(1'b0, 32'h00000100, 32'h0);
    `CHK(rd, 32'h0)
    $display("test unmapped done");
    complete_run();
  end
endmodule
